// [core/mced_pkg.sv]
// Shared constants and types for the instruction execution block.
`default_nettype none

package mced_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses on the register bus)
	// ------------------------------------------------------------
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  OFS_INSTR    = 8'h00;
	localparam logic [7:0]  OFS_ACC      = 8'h04;
	localparam logic [7:0]  OFS_STATUS   = 8'h08;
	localparam logic [7:0]  OFS_FILEIDX  = 8'h0C;
	localparam logic [7:0]  OFS_FILEDATA = 8'h10;
	localparam logic [7:0]  OFS_CTRL     = 8'h14;

	// ------------------------------------------------------------
	// Instruction word layout and operation codes
	// ------------------------------------------------------------
	localparam int          INSTR_W      = 16;
	localparam int          OP_LSB       = 8;
	localparam int          DEST_BIT     = 7;
	localparam int          RADDR_W      = 7;
	localparam logic [7:0]  OPC_CLR      = 8'h01;
	localparam logic [7:0]  OPC_INV      = 8'h02;
	localparam logic [7:0]  OPC_WDT      = 8'h03;
	localparam logic [7:0]  OPC_CMP      = 8'h04;
	localparam logic [7:0]  OPC_DAA      = 8'h05;
	localparam logic [7:0]  OPC_DECSZ    = 8'h06;

	// ------------------------------------------------------------
	// Status and control bit positions, reset values
	// ------------------------------------------------------------
	localparam int          ST_Z         = 0;
	localparam int          ST_C         = 1;
	localparam int          ST_DC        = 2;
	localparam int          ST_PD        = 3;
	localparam int          ST_TO        = 4;
	localparam int          ST_BUSY      = 5;
	localparam int          ST_BADOP     = 6;
	localparam int          CTRL_PSA     = 0;
	localparam logic [7:0]  ACC_RST      = 8'h00;
	localparam logic        TO_N_RST     = 1'b1;
	localparam logic        PD_N_RST     = 1'b1;
	localparam logic        PSA_RST      = 1'b1;
	localparam int          SKIP_CYCLES  = 2;

	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {PH_IDLE, PH_EXEC, PH_NOP} mced_phase_t;

	typedef struct packed {
		logic                 awHave;
		logic [ADDR_W-1:0]    awAddr;
		logic                 wHave;
		logic [31:0]          wData;
		logic [3:0]           wStrb;
		logic                 bValid;
		logic [1:0]           bResp;
		logic                 rValid;
		logic [31:0]          rData;
		logic [1:0]           rResp;
		mced_phase_t          phase;
		logic [INSTR_W-1:0]   instr;
		logic [7:0]           acc;
		logic                 zero;
		logic                 carry;
		logic                 digitCarry;
		logic                 toN;
		logic                 pdN;
		logic                 badOp;
		logic                 prescAssigned;
		logic [RADDR_W-1:0]   fileIdx;
		logic                 wdtClr;
		logic                 prsClr;
		logic                 skipPulse;
	} mced_state_t;

endpackage : mced_pkg

`default_nettype wire

// [core/mced_exec.sv]
// Instruction executor for clear, invert, watchdog clear, compare, decimal
// adjust and decrement-skip, with an AXI4-Lite register port.
`default_nettype none

module mced_exec #(
	parameter int FILE_DEPTH = 128
) (
	input  wire logic                      mclk,
	input  wire logic                      rst,
	input  wire logic [mced_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [mced_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic                           watchdogClear,
	output logic                           prescalerClear,
	output logic                           skipDiscard,
	output logic                           busy
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Zero test shared by the invert, compare and decrement-skip operations.
	function automatic logic isZero(input logic [7:0] v);
		isZero = (v == 8'h00);
	endfunction : isZero

	// Packed decimal correction; bit 8 is the resulting carry.
	function automatic logic [8:0] daaAdjust(
		input logic [7:0] v,
		input logic       c,
		input logic       dc
	);
		logic [8:0] t;
		t = {1'b0, v};
		if (dc || (t[3:0] > 4'h9))
			t = t + 9'h006;
		if (c || t[8] || (t[7:4] > 4'h9))
			t = t + 9'h060;
		daaAdjust = {t[8] | c, t[7:0]};
	endfunction : daaAdjust

	// Maps a byte address onto the register map; unmapped gives 0.
	function automatic logic isMapped(input logic [mced_pkg::ADDR_W-1:0] a);
		isMapped = (a == mced_pkg::OFS_INSTR) || (a == mced_pkg::OFS_ACC) ||
			(a == mced_pkg::OFS_STATUS) || (a == mced_pkg::OFS_FILEIDX) ||
			(a == mced_pkg::OFS_FILEDATA) || (a == mced_pkg::OFS_CTRL);
	endfunction : isMapped

	// ------------------------------------------------------------
	// State and data register file
	// ------------------------------------------------------------
	mced_pkg::mced_state_t state_r;
	mced_pkg::mced_state_t state_nxt;

	logic [7:0]                    fileMem [FILE_DEPTH];
	logic                          fileWe;
	logic [mced_pkg::RADDR_W-1:0]  fileWa;
	logic [7:0]                    fileWd;

	logic [7:0]                    opCode;
	logic                          destReg;
	logic [mced_pkg::RADDR_W-1:0]  opAddr;
	logic [7:0]                    operand;
	logic [7:0]                    result;
	logic [8:0]                    diff;
	logic [8:0]                    adj;
	logic [7:0]                    statusByte;
	logic [31:0]                   readWord;
	logic                          commitWr;

	// Instruction fields and operand fetch (seven-bit direct address).
	assign opCode  = state_r.instr[mced_pkg::OP_LSB +: 8];
	assign destReg = state_r.instr[mced_pkg::DEST_BIT];
	assign opAddr  = state_r.instr[mced_pkg::RADDR_W-1:0];
	assign operand = fileMem[opAddr];

	// Handshake outputs; writes stall while an instruction is in flight.
	assign s_axi_awready = !state_r.awHave && !state_r.bValid &&
		(state_r.phase == mced_pkg::PH_IDLE);
	assign s_axi_wready  = !state_r.wHave && !state_r.bValid &&
		(state_r.phase == mced_pkg::PH_IDLE);
	assign s_axi_arready = !state_r.rValid;
	assign s_axi_bvalid  = state_r.bValid;
	assign s_axi_bresp   = state_r.bResp;
	assign s_axi_rvalid  = state_r.rValid;
	assign s_axi_rdata   = state_r.rData;
	assign s_axi_rresp   = state_r.rResp;

	// Side-band pulses to the watchdog and the fetch stage.
	assign watchdogClear  = state_r.wdtClr;
	assign prescalerClear = state_r.prsClr;
	assign skipDiscard    = state_r.skipPulse;
	assign busy           = (state_r.phase != mced_pkg::PH_IDLE);

	// Status word as software sees it.
	always_comb
	begin
		statusByte = 8'h00;
		statusByte[mced_pkg::ST_Z]     = state_r.zero;
		statusByte[mced_pkg::ST_C]     = state_r.carry;
		statusByte[mced_pkg::ST_DC]    = state_r.digitCarry;
		statusByte[mced_pkg::ST_PD]    = state_r.pdN;
		statusByte[mced_pkg::ST_TO]    = state_r.toN;
		statusByte[mced_pkg::ST_BUSY]  = busy;
		statusByte[mced_pkg::ST_BADOP] = state_r.badOp;
	end

	// Read data mux; unmapped addresses read as zero.
	always_comb
	begin
		readWord = 32'h0000_0000;
		case (s_axi_araddr)
			mced_pkg::OFS_INSTR:    readWord[15:0] = state_r.instr;
			mced_pkg::OFS_ACC:      readWord[7:0]  = state_r.acc;
			mced_pkg::OFS_STATUS:   readWord[7:0]  = statusByte;
			mced_pkg::OFS_FILEIDX:  readWord[6:0]  = state_r.fileIdx;
			mced_pkg::OFS_FILEDATA: readWord[7:0]  = fileMem[state_r.fileIdx];
			mced_pkg::OFS_CTRL:
				readWord[mced_pkg::CTRL_PSA] = state_r.prescAssigned;
			default:                readWord = 32'h0000_0000;
		endcase
	end

	// Compare difference and decimal correction, both used in execution.
	assign diff = {1'b0, operand} + {1'b0, ~state_r.acc} + 9'h001;
	assign adj  = daaAdjust(state_r.acc, state_r.carry, state_r.digitCarry);
	assign commitWr = state_r.awHave && state_r.wHave && !state_r.bValid;

	// ------------------------------------------------------------
	// Next-state logic: bus slave, then instruction execution
	// ------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		fileWe = 1'b0;
		fileWa = state_r.fileIdx;
		fileWd = 8'h00;
		result = 8'h00;
		state_nxt.wdtClr    = 1'b0;
		state_nxt.prsClr    = 1'b0;
		state_nxt.skipPulse = 1'b0;

		// Address and data are caught independently, in either order.
		if (s_axi_awvalid && s_axi_awready)
		begin
			state_nxt.awHave = 1'b1;
			state_nxt.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			state_nxt.wHave = 1'b1;
			state_nxt.wData = s_axi_wdata;
			state_nxt.wStrb = s_axi_wstrb;
		end
		if (state_r.bValid && s_axi_bready)
			state_nxt.bValid = 1'b0;

		// Read answer one cycle after the address is taken.
		if (s_axi_arvalid && s_axi_arready)
		begin
			state_nxt.rValid = 1'b1;
			state_nxt.rData  = readWord;
			state_nxt.rResp  = isMapped(s_axi_araddr) ?
				mced_pkg::RESP_OKAY : mced_pkg::RESP_SLVERR;
		end
		else if (state_r.rValid && s_axi_rready)
			state_nxt.rValid = 1'b0;

		// A complete write commits only while idle, so software never
		// races the execution stage on the same storage.
		if (commitWr)
		begin
			state_nxt.awHave = 1'b0;
			state_nxt.wHave  = 1'b0;
			state_nxt.bValid = 1'b1;
			state_nxt.bResp  = isMapped(state_r.awAddr) ?
				mced_pkg::RESP_OKAY : mced_pkg::RESP_SLVERR;
			case (state_r.awAddr)
				mced_pkg::OFS_INSTR:
					if (state_r.wStrb[1:0] == 2'b11)
					begin
						state_nxt.instr = state_r.wData[15:0];
						state_nxt.phase = mced_pkg::PH_EXEC;
					end
				mced_pkg::OFS_ACC:
					if (state_r.wStrb[0])
						state_nxt.acc = state_r.wData[7:0];
				mced_pkg::OFS_STATUS:
					if (state_r.wStrb[0])
					begin
						state_nxt.zero       = state_r.wData[mced_pkg::ST_Z];
						state_nxt.carry      = state_r.wData[mced_pkg::ST_C];
						state_nxt.digitCarry = state_r.wData[mced_pkg::ST_DC];
						state_nxt.badOp      = 1'b0;
					end
				mced_pkg::OFS_FILEIDX:
					if (state_r.wStrb[0])
						state_nxt.fileIdx = state_r.wData[6:0];
				mced_pkg::OFS_FILEDATA:
					if (state_r.wStrb[0])
					begin
						fileWe = 1'b1;
						fileWd = state_r.wData[7:0];
					end
				mced_pkg::OFS_CTRL:
					if (state_r.wStrb[0])
						state_nxt.prescAssigned =
							state_r.wData[mced_pkg::CTRL_PSA];
				default:
					state_nxt.bResp = mced_pkg::RESP_SLVERR;
			endcase
		end

		// Execution; an operation retires in this cycle, or after one more no-op cycle when decrement-skip skips.
		case (state_r.phase)
			mced_pkg::PH_IDLE:
				;
			mced_pkg::PH_EXEC:
			begin
				state_nxt.phase = mced_pkg::PH_IDLE;
				fileWa = opAddr;
				case (opCode)
					mced_pkg::OPC_CLR:
					begin
						fileWe = 1'b1;
						fileWd = 8'h00;
						state_nxt.zero = 1'b1;
					end
					mced_pkg::OPC_INV:
					begin
						result = ~operand;
						state_nxt.zero = isZero(result);
						if (destReg)
						begin
							fileWe = 1'b1;
							fileWd = result;
						end
						else
							state_nxt.acc = result;
					end
					mced_pkg::OPC_WDT:
					begin
						state_nxt.wdtClr = 1'b1;
						state_nxt.prsClr = state_r.prescAssigned;
						state_nxt.toN = 1'b1;
						state_nxt.pdN = 1'b1;
					end
					mced_pkg::OPC_CMP:
					begin
						// Only flags change; no storage is written.
						state_nxt.zero  = isZero(diff[7:0]);
						state_nxt.carry = diff[8];
					end
					mced_pkg::OPC_DAA:
					begin
						// Relies on the preceding add leaving C and DC.
						state_nxt.acc   = adj[7:0];
						state_nxt.carry = adj[8];
					end
					mced_pkg::OPC_DECSZ:
					begin
						result = operand - 8'h01;
						if (destReg)
						begin
							fileWe = 1'b1;
							fileWd = result;
						end
						else
							state_nxt.acc = result;
						if (isZero(result))
						begin
							// The fetched word is dropped; a no-op follows.
							state_nxt.skipPulse = 1'b1;
							state_nxt.phase = mced_pkg::PH_NOP;
						end
					end
					default:
						state_nxt.badOp = 1'b1;
				endcase
			end
			mced_pkg::PH_NOP:
				// Second cycle of a skipping instruction does nothing.
				state_nxt.phase = mced_pkg::PH_IDLE;
			default:
				state_nxt.phase = mced_pkg::PH_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------

	// Synchronous reset to constants only.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_r               <= '0;
			state_r.phase         <= mced_pkg::PH_IDLE;
			state_r.acc           <= mced_pkg::ACC_RST;
			state_r.toN           <= mced_pkg::TO_N_RST;
			state_r.pdN           <= mced_pkg::PD_N_RST;
			state_r.prescAssigned <= mced_pkg::PSA_RST;
		end
		else
			state_r <= state_nxt;
	end

	// Data registers are not reset; software or code initialises them.
	always_ff @(posedge mclk)
	begin
		if (fileWe)
			fileMem[fileWa] <= fileWd;
	end

endmodule : mced_exec

`default_nettype wire

// [testbench/mced_checker.sv]
// Port checker for the instruction execution block.
`default_nettype none

module mced_checker (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        watchdogClear,
	input wire logic        prescalerClear,
	input wire logic        skipDiscard,
	input wire logic        busy
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// Execution timing
	// ------------------------------------------------------------
	// A plain instruction is busy one cycle, a skipping one two.
	sequence busyTwice;
		busy ##1 busy;
	endsequence
	sequence nopThenIdle;
		busy ##1 !busy;
	endsequence

	busy_bound_a: assert property (busyTwice |=> !busy)
		else $error("busy lasted more than two cycles");
	skip_nop_a: assert property (skipDiscard |-> nopThenIdle)
		else $error("skip pulse outside the no-op cycle");
	skip_after_a: assert property (skipDiscard |-> $past(busy))
		else $error("skip pulse without a preceding execute cycle");
	wd_pulse_a: assert property (watchdogClear |=> !watchdogClear)
		else $error("watchdog clear longer than one cycle");
	wd_cause_a: assert property (watchdogClear |-> !busy && $past(busy))
		else $error("watchdog clear not right after execution");
	ps_with_wd_a: assert property (prescalerClear |-> watchdogClear)
		else $error("prescaler clear without watchdog clear");

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	// Answers must stand until taken, or the master loses them.
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped before taken");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped before taken");
	aw_wait_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address accepted during answer");
endmodule : mced_checker

bind mced_exec mced_checker i_chk (
	.mclk, .rst, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .watchdogClear, .prescalerClear, .skipDiscard, .busy
);

`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the instruction execution block.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam logic [31:0] stIdle = 32'h0000_0018;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        watchdogClear, prescalerClear, skipDiscard, busy;
	int          miscompares = 0;
	int          comparisons = 0;
	int          nWd, nPs, nSkip, nBusy;

	mced_exec i_dut (
		.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .watchdogClear, .prescalerClear,
		.skipDiscard, .busy
	);

	initial
	begin
		forever #20 mclk = ~mclk;
	end

	// Pulses are tallied mid-cycle, where every output has settled.
	always @(negedge mclk)
	begin
		nWd += int'(watchdogClear === 1'b1);
		nPs += int'(prescalerClear === 1'b1);
		nSkip += int'(skipDiscard === 1'b1);
		nBusy += int'(busy === 1'b1);
	end

	// ------------------------------------------------------------
	// Compare and bus tasks
	// ------------------------------------------------------------
	task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chkWord

	task automatic chkCnt(input int got, input int exp);
		comparisons++;
		if (got != exp)
		begin
			miscompares++;
			$display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
		end
	endtask : chkCnt

	// Readiness is sampled mid-cycle and acted on at the next edge,
	// so a channel is released only after the edge that takes it.
	// A nonzero lag holds the answer ready low for that many edges, so
	// the slave must keep its answer standing; one idle edge follows
	// every transfer so that no strobe is set twice in one time step.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = mced_pkg::RESP_OKAY, input int lag = 0);
		logic       ta;
		logic       tw;
		logic       done;
		logic [1:0] r;
		int         n;
		done = 1'b0;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (lag == 0);
		while (!done)
		begin
			@(negedge mclk);
			ta = s_axi_awvalid && s_axi_awready === 1'b1;
			tw = s_axi_wvalid && s_axi_wready === 1'b1;
			done = s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1;
			r = s_axi_bresp;
			@(posedge mclk);
			n++;
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (n == lag) s_axi_bready <= 1'b1;
		end
		s_axi_bready <= 1'b0;
		@(posedge mclk);
		chkWord(32'(r), 32'(er));
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er = mced_pkg::RESP_OKAY, input int lag = 0);
		logic        t;
		logic        done;
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		done = 1'b0;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (lag == 0);
		while (!done)
		begin
			@(negedge mclk);
			t = s_axi_arvalid && s_axi_arready === 1'b1;
			done = s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge mclk);
			n++;
			if (t) s_axi_arvalid <= 1'b0;
			if (n == lag) s_axi_rready <= 1'b1;
		end
		s_axi_rready <= 1'b0;
		@(posedge mclk);
		chkWord(d, ed);
		chkWord(32'(r), 32'(er));
	endtask : rd

	task automatic setReg(input logic [6:0] i, input logic [7:0] v);
		wr(mced_pkg::OFS_FILEIDX, 32'(i));
		wr(mced_pkg::OFS_FILEDATA, 32'(v));
	endtask : setReg

	task automatic chkReg(input logic [6:0] i, input logic [7:0] v);
		wr(mced_pkg::OFS_FILEIDX, 32'(i));
		rd(mced_pkg::OFS_FILEDATA, 32'(v));
	endtask : chkReg

	// Commit an instruction, let it retire, then judge the side pulses.
	task automatic exec(input logic [15:0] op, input int wd, ps, sk, bz);
		nWd = 0;
		nPs = 0;
		nSkip = 0;
		nBusy = 0;
		wr(mced_pkg::OFS_INSTR, 32'(op));
		repeat (4) @(posedge mclk);
		chkCnt(nWd, wd);
		chkCnt(nPs, ps);
		chkCnt(nSkip, sk);
		chkCnt(nBusy, bz);
	endtask : exec

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// The late-ready calls make the answers wait before being taken.
	task automatic tReset();
		rd(mced_pkg::OFS_STATUS, stIdle, mced_pkg::RESP_OKAY, 3);
		rd(mced_pkg::OFS_CTRL, 32'h0000_0001);
		rd(8'h40, 32'h0000_0000, mced_pkg::RESP_SLVERR);
		wr(8'h40, 32'h0000_00FF, mced_pkg::RESP_SLVERR, 3);
	endtask : tReset

	// The top register checks the edge of the address range.
	task automatic tClear();
		setReg(7'h7F, 8'h55);
		wr(mced_pkg::OFS_STATUS, 32'h0000_0000);
		exec({mced_pkg::OPC_CLR, 8'h7F}, 0, 0, 0, 1);
		chkReg(7'h7F, 8'h00);
		rd(mced_pkg::OFS_STATUS, stIdle | 32'h0000_0001);
	endtask : tClear

	task automatic tInvert();
		setReg(7'h03, 8'hA6);
		wr(mced_pkg::OFS_STATUS, 32'h0000_0001);
		exec({mced_pkg::OPC_INV, 8'h83}, 0, 0, 0, 1);
		chkReg(7'h03, 8'h59);
		rd(mced_pkg::OFS_STATUS, stIdle);
		setReg(7'h04, 8'hFF);
		wr(mced_pkg::OFS_ACC, 32'h0000_0033);
		exec({mced_pkg::OPC_INV, 8'h04}, 0, 0, 0, 1);
		rd(mced_pkg::OFS_ACC, 32'h0000_0000);
		chkReg(7'h04, 8'hFF);
		rd(mced_pkg::OFS_STATUS, stIdle | 32'h0000_0001);
	endtask : tInvert

	// Flags are cleared first so the status read shows only TO and PD.
	task automatic tWatchdog();
		wr(mced_pkg::OFS_STATUS, 32'h0000_0000);
		for (int p = 0; p < 2; p++)
		begin
			wr(mced_pkg::OFS_CTRL, 32'(p));
			exec({mced_pkg::OPC_WDT, 8'h00}, 1, p, 0, 1);
			rd(mced_pkg::OFS_STATUS, stIdle);
		end
	endtask : tWatchdog

	task automatic tCompare(input logic [7:0] r, a, input logic [31:0] st);
		setReg(7'h09, r);
		wr(mced_pkg::OFS_ACC, 32'(a));
		wr(mced_pkg::OFS_STATUS, 32'h0000_0000);
		exec({mced_pkg::OPC_CMP, 8'h09}, 0, 0, 0, 1);
		rd(mced_pkg::OFS_STATUS, st);
		rd(mced_pkg::OFS_ACC, 32'(a));
		chkReg(7'h09, r);
	endtask : tCompare

	// Zero is set beforehand to show the adjust leaves it alone.
	task automatic tDecAdj();
		wr(mced_pkg::OFS_ACC, 32'h0000_004D);
		wr(mced_pkg::OFS_STATUS, 32'h0000_0001);
		exec({mced_pkg::OPC_DAA, 8'h00}, 0, 0, 0, 1);
		rd(mced_pkg::OFS_ACC, 32'h0000_0053);
		rd(mced_pkg::OFS_STATUS, stIdle | 32'h0000_0001);
		wr(mced_pkg::OFS_ACC, 32'h0000_009A);
		wr(mced_pkg::OFS_STATUS, 32'h0000_0000);
		exec({mced_pkg::OPC_DAA, 8'h00}, 0, 0, 0, 1);
		rd(mced_pkg::OFS_ACC, 32'h0000_0000);
		rd(mced_pkg::OFS_STATUS, stIdle | 32'h0000_0002);
	endtask : tDecAdj

	task automatic tDecSkip();
		setReg(7'h01, 8'h01);
		exec({mced_pkg::OPC_DECSZ, 8'h81}, 0, 0, 1, mced_pkg::SKIP_CYCLES);
		chkReg(7'h01, 8'h00);
		setReg(7'h02, 8'h05);
		exec({mced_pkg::OPC_DECSZ, 8'h02}, 0, 0, 0, 1);
		rd(mced_pkg::OFS_ACC, 32'h0000_0004);
		chkReg(7'h02, 8'h05);
	endtask : tDecSkip

	// An opcode outside the six flags BADOP until software clears it.
	task automatic tBadOp();
		wr(mced_pkg::OFS_STATUS, 32'h0000_0000);
		exec({8'h07, 8'h00}, 0, 0, 0, 1);
		rd(mced_pkg::OFS_STATUS,
			stIdle | (32'h0000_0001 << mced_pkg::ST_BADOP));
		wr(mced_pkg::OFS_STATUS, 32'h0000_0000);
		rd(mced_pkg::OFS_STATUS, stIdle);
	endtask : tBadOp

	task automatic results();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	initial
	begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		tReset();
		tClear();
		tInvert();
		tWatchdog();
		tCompare(8'h34, 8'h12, stIdle | 32'h0000_0002);
		tCompare(8'h20, 8'h20, stIdle | 32'h0000_0003);
		tCompare(8'h10, 8'h11, stIdle);
		tDecAdj();
		tDecSkip();
		tBadOp();
		results();
	end

	// The tests need under a thousand cycles; twenty thousand is a hang.
	initial
	begin
		#(20000 * 40);
		miscompares++;
		results();
	end
endmodule : tb_top

`default_nettype wire
